// File: rtl/flash_host_ctrl.sv
// host controller for a byte-wide parallel nor flash, commanded over axi4-lite
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
module flash_host_ctrl
  import flash_host_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [FLASH_ADDR_W-1:0] flash_addr,
  output logic chip_sel_n,
  output logic write_en_n,
  output logic out_en_n,
  output logic [FLASH_DATA_W-1:0] data_lines_out,
  output logic data_lines_oe,
  input wire logic [FLASH_DATA_W-1:0] data_lines_in,
  output logic flash_reset_n,
  input wire logic ready_busy_out_n,
  output logic irq
);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {S_IDLE, S_CYCLE, S_BUSY_WIN, S_WAIT_RDY, S_RST_PULSE,
                            S_RST_RECOV} state_e;

  bus_cycle_if cyc();

  flash_bus_cycle u_cycle (
    .clock(clock),
    .rst_b(rst_b),
    .cyc(cyc.cycle),
    .flash_addr(flash_addr),
    .chip_sel_n(chip_sel_n),
    .write_en_n(write_en_n),
    .out_en_n(out_en_n),
    .data_lines_out(data_lines_out),
    .data_lines_oe(data_lines_oe),
    .data_lines_in(data_lines_in)
  );

  // ready/busy pin synchroniser; high means ready
  logic rb_meta, rb_ready;

  // register group
  logic aw_held, next_aw_held, w_held, next_w_held, next_bvalid, next_rvalid;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data, next_rdata, wmask;
  logic [3:0] w_strb, next_w_strb;
  logic [1:0] next_bresp, next_rresp;
  logic [FLASH_ADDR_W-1:0] addr_reg, next_addr_reg;
  logic [FLASH_DATA_W-1:0] wdata_reg, next_wdata_reg;
  logic [IRQ_W-1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
  logic wr_fire, start_req;

  // control group
  state_e state, next_state;
  logic [2:0] step, next_step;
  logic [15:0] cnt, next_cnt;
  logic launched, next_launched, nowait, next_nowait, susp, next_susp;
  logic bypass, next_bypass, rst_pin, next_rst_pin, ev_done, ev_reject;
  op_t op, next_op;
  logic [FLASH_DATA_W-1:0] rd_byte, next_rd_byte;
  step_s cur;

  assign flash_reset_n = rst_pin;
  assign irq = |(irq_stat & irq_mask);
  assign awready = !aw_held;
  assign wready = !w_held;
  assign arready = !rvalid;
  assign wr_fire = aw_held && w_held && !bvalid;
  assign start_req = wr_fire && aw_addr == REG_CTRL && w_strb[0];
  assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign cur = seq_step(op, step, addr_reg, wdata_reg);
  assign cyc.start = (state == S_CYCLE) && !launched;
  assign cyc.write = (op != OP_READ);
  assign cyc.addr = (op == OP_READ) ? addr_reg : cur.addr;
  assign cyc.wdata = cur.data;

  always_comb begin
    next_aw_held = aw_held || awvalid;
    next_aw_addr = (!aw_held && awvalid) ? awaddr : aw_addr;
    next_w_held = w_held || wvalid;
    next_w_data = (!w_held && wvalid) ? wdata : w_data;
    next_w_strb = (!w_held && wvalid) ? wstrb : w_strb;
    next_bvalid = bvalid && !bready;
    next_bresp = bresp;
    next_rvalid = rvalid && !rready;
    next_rdata = rdata;
    next_rresp = rresp;
    next_addr_reg = addr_reg;
    next_wdata_reg = wdata_reg;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      case (aw_addr)
        REG_CTRL, REG_RDATA, REG_STATUS: ;
        REG_ADDR: next_addr_reg = FLASH_ADDR_W'(({11'h000, addr_reg} & ~wmask) | (w_data & wmask));
        REG_WDATA: if (w_strb[0]) next_wdata_reg = w_data[FLASH_DATA_W-1:0];
        REG_IRQ_STAT: if (w_strb[0]) next_irq_stat = irq_stat & ~w_data[IRQ_W-1:0];
        REG_IRQ_MASK: if (w_strb[0]) next_irq_mask = w_data[IRQ_W-1:0];
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    // events win over a simultaneous clear
    next_irq_stat[IRQ_DONE] = next_irq_stat[IRQ_DONE] | ev_done;
    next_irq_stat[IRQ_REJECT] = next_irq_stat[IRQ_REJECT] | ev_reject;
    if (arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      case (araddr)
        REG_CTRL: next_rdata = 32'({nowait, op});
        REG_ADDR: next_rdata = 32'(addr_reg);
        REG_WDATA: next_rdata = 32'(wdata_reg);
        REG_RDATA: next_rdata = 32'(rd_byte);
        REG_STATUS: next_rdata = 32'({rb_ready, bypass, susp, state != S_IDLE});
        REG_IRQ_STAT: next_rdata = 32'(irq_stat);
        REG_IRQ_MASK: next_rdata = 32'(irq_mask);
        default: begin
          next_rdata = '0;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_comb begin
    next_state = state;
    next_step = step;
    next_cnt = cnt;
    next_launched = launched;
    next_nowait = nowait;
    next_susp = susp;
    next_bypass = bypass;
    next_rst_pin = 1'b1;
    next_op = op;
    next_rd_byte = rd_byte;
    ev_done = 1'b0;
    ev_reject = 1'b0;
    // orders arriving while busy are refused
    if (start_req && state != S_IDLE) ev_reject = 1'b1;
    case (state)
      S_IDLE: if (start_req) begin
        next_op = w_data[3:0];
        next_nowait = w_data[CTRL_NOWAIT_BIT];
        next_step = '0;
        next_launched = 1'b0;
        next_cnt = '0;
        if (w_data[3:0] > OP_LAST) ev_reject = 1'b1;
        else if (w_data[3:0] == OP_WAIT_READY) next_state = S_WAIT_RDY;
        else if (w_data[3:0] == OP_HW_RESET) next_state = S_RST_PULSE;
        else next_state = S_CYCLE;
      end
      S_CYCLE: begin
        if (cyc.start) next_launched = 1'b1;
        if (cyc.done) begin
          next_launched = 1'b0;
          next_step = step + 3'd1;
          if (op == OP_READ) begin
            // erased bytes come back as all ones
            next_rd_byte = cyc.rdata;
            next_state = S_IDLE;
            ev_done = 1'b1;
          end else if (cur.last) begin
            next_cnt = '0;
            // device runs its own algorithm; watch for busy
            if ((op == OP_PROGRAM || op == OP_BYPASS_PROG || op == OP_SECTOR_ERASE ||
                 op == OP_CHIP_ERASE) && !nowait) next_state = S_BUSY_WIN;
            // suspend completes when the device reports ready
            else if (op == OP_SUSPEND) next_state = S_WAIT_RDY;
            else begin
              next_state = S_IDLE;
              ev_done = 1'b1;
            end
            if (op == OP_BYPASS_ENTER) next_bypass = 1'b1;
            if (op == OP_BYPASS_EXIT || op == OP_SW_RESET) next_bypass = 1'b0;
            if (op == OP_RESUME || op == OP_SECTOR_ERASE || op == OP_CHIP_ERASE) next_susp = 1'b0;
          end
        end
      end
      S_BUSY_WIN: begin
        next_cnt = cnt + 16'h0001;
        if (!rb_ready) next_state = S_WAIT_RDY;
        // protected target: device never went busy
        else if (cnt == BUSY_CYC + SYNC_CYC) begin
          next_state = S_IDLE;
          ev_reject = 1'b1;
        end
      end
      S_WAIT_RDY: if (rb_ready) begin
        // ready again for reads and commands
        next_state = S_IDLE;
        ev_done = 1'b1;
        if (op == OP_SUSPEND) next_susp = 1'b1;
      end
      S_RST_PULSE: begin
        next_rst_pin = 1'b0;
        next_cnt = cnt + 16'h0001;
        if (cnt == RP_CYC - 16'h0001) begin
          next_rst_pin = 1'b1;
          next_cnt = '0;
          next_state = S_RST_RECOV;
        end
      end
      S_RST_RECOV: begin
        next_cnt = cnt + 16'h0001;
        if (cnt == RH_CYC - 16'h0001) begin
          next_state = S_IDLE;
          next_susp = 1'b0;
          next_bypass = 1'b0;
          ev_done = 1'b1;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rb_meta <= 1'b1;
      rb_ready <= 1'b1;
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
      addr_reg <= '0;
      wdata_reg <= '0;
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      rb_meta <= ready_busy_out_n;
      rb_ready <= rb_meta;
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      addr_reg <= next_addr_reg;
      wdata_reg <= next_wdata_reg;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
    end
  end

  // start-up begins with a reset pulse so the device boots in read mode
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= S_RST_PULSE;
      step <= '0;
      cnt <= '0;
      launched <= 1'b0;
      nowait <= 1'b0;
      susp <= 1'b0;
      bypass <= 1'b0;
      rst_pin <= 1'b0;
      op <= OP_HW_RESET;
      rd_byte <= '0;
    end else begin
      state <= next_state;
      step <= next_step;
      cnt <= next_cnt;
      launched <= next_launched;
      nowait <= next_nowait;
      susp <= next_susp;
      bypass <= next_bypass;
      rst_pin <= next_rst_pin;
      op <= next_op;
      rd_byte <= next_rd_byte;
    end
  end
endmodule // flash_host_ctrl

// File: rtl/flash_host_pkg.sv
// constants, register map and command sequences for the parallel flash host controller
package flash_host_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int FLASH_ADDR_W = 21;
  localparam int FLASH_DATA_W = 8;
  localparam int FLASH_BYTES = 2097152;
  localparam int SECTOR_COUNT = 32;
  localparam int SECTOR_BYTES = 65536;

  // pin timing in ns, converted to clock cycles (least times round up)
  localparam int T_WP_NS = 45;
  localparam int T_WPH_NS = 30;
  localparam int T_ACC_NS = 120;
  localparam int T_BUSY_NS = 90;
  localparam int T_RP_NS = 500;
  localparam int T_RH_NS = 20000;
  localparam logic [15:0] WP_CYC = 16'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] WPH_CYC = 16'((T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] ACC_CYC = 16'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] BUSY_CYC = 16'((T_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] RP_CYC = 16'((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] RH_CYC = 16'((T_RH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] SYNC_CYC = 16'h0002;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;
  localparam int CTRL_NOWAIT_BIT = 4;
  localparam int ST_BUSY = 0;
  localparam int ST_SUSP = 1;
  localparam int ST_BYPASS = 2;
  localparam int ST_READY_PIN = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_REJECT = 1;
  localparam int IRQ_W = 2;

  typedef logic [3:0] op_t;
  localparam op_t OP_READ = 4'h0;
  localparam op_t OP_PROGRAM = 4'h1;
  localparam op_t OP_SECTOR_ERASE = 4'h2;
  localparam op_t OP_CHIP_ERASE = 4'h3;
  localparam op_t OP_SUSPEND = 4'h4;
  localparam op_t OP_RESUME = 4'h5;
  localparam op_t OP_SW_RESET = 4'h6;
  localparam op_t OP_BYPASS_ENTER = 4'h7;
  localparam op_t OP_BYPASS_PROG = 4'h8;
  localparam op_t OP_BYPASS_EXIT = 4'h9;
  localparam op_t OP_HW_RESET = 4'ha;
  localparam op_t OP_SECTOR_ADD = 4'hb;
  localparam op_t OP_WAIT_READY = 4'hc;
  localparam op_t OP_LAST = 4'hc;

  // bus command codes and unlock addresses
  localparam logic [FLASH_ADDR_W-1:0] UNLOCK_ADDR1 = 21'h000555;
  localparam logic [FLASH_ADDR_W-1:0] UNLOCK_ADDR2 = 21'h0002aa;
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_BYPASS_EXIT1 = 8'h90;
  localparam logic [7:0] CMD_BYPASS_EXIT2 = 8'h00;

  typedef struct packed {
    logic last;
    logic [FLASH_ADDR_W-1:0] addr;
    logic [FLASH_DATA_W-1:0] data;
  } step_s;

  // one bus write of a command sequence
  function automatic step_s seq_step(input op_t op, input logic [2:0] idx,
                                     input logic [FLASH_ADDR_W-1:0] a,
                                     input logic [FLASH_DATA_W-1:0] d);
    step_s s;
    s.last = 1'b0;
    s.addr = (idx == 3'd1 || idx == 3'd4) ? UNLOCK_ADDR2 : UNLOCK_ADDR1;
    s.data = (idx == 3'd1 || idx == 3'd4) ? CMD_UNLOCK2 : CMD_UNLOCK1;
    case (op)
      OP_PROGRAM: begin
        if (idx == 3'd2) s.data = CMD_PROGRAM;
        if (idx == 3'd3) s = '{1'b1, a, d};
      end
      OP_SECTOR_ERASE, OP_CHIP_ERASE: begin
        if (idx == 3'd2) s.data = CMD_ERASE_SETUP;
        if (idx == 3'd5) begin
          s.last = 1'b1;
          s.addr = (op == OP_CHIP_ERASE) ? UNLOCK_ADDR1 : a;
          s.data = (op == OP_CHIP_ERASE) ? CMD_CHIP_ERASE : CMD_SECTOR_ERASE;
        end
      end
      OP_BYPASS_ENTER: begin
        if (idx == 3'd2) s = '{1'b1, UNLOCK_ADDR1, CMD_BYPASS};
      end
      OP_BYPASS_PROG: s = (idx == 3'd0) ? step_s'{1'b0, a, CMD_PROGRAM} : step_s'{1'b1, a, d};
      OP_BYPASS_EXIT: s = (idx == 3'd0) ? step_s'{1'b0, a, CMD_BYPASS_EXIT1}
        : step_s'{1'b1, a, CMD_BYPASS_EXIT2};
      OP_SUSPEND: s = '{1'b1, a, CMD_SUSPEND};
      OP_RESUME: s = '{1'b1, a, CMD_RESUME};
      OP_SECTOR_ADD: s = '{1'b1, a, CMD_SECTOR_ERASE};
      default: s = '{1'b1, a, CMD_RESET};
    endcase
    return s;
  endfunction
endpackage

// File: rtl/bus_cycle_if.sv
// request and answer of one flash pin cycle
`timescale 1ns/100ps
interface bus_cycle_if;
  import flash_host_pkg::*;
  logic start;
  logic write;
  logic [FLASH_ADDR_W-1:0] addr;
  logic [FLASH_DATA_W-1:0] wdata;
  logic done;
  logic [FLASH_DATA_W-1:0] rdata;
  modport issuer (output start, output write, output addr, output wdata,
                  input done, input rdata);
  modport cycle (input start, input write, input addr, input wdata,
                 output done, output rdata);
endinterface

// File: rtl/flash_bus_cycle.sv
// one asynchronous read or write cycle on the flash pins
`timescale 1ns/100ps
module flash_bus_cycle
  import flash_host_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  bus_cycle_if.cycle cyc,
  output logic [FLASH_ADDR_W-1:0] flash_addr,
  output logic chip_sel_n,
  output logic write_en_n,
  output logic out_en_n,
  output logic [FLASH_DATA_W-1:0] data_lines_out,
  output logic data_lines_oe,
  input wire logic [FLASH_DATA_W-1:0] data_lines_in
);
  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_PULSE, C_RECOV} cyc_state_e;
  cyc_state_e state, next_state;
  logic [15:0] cnt, next_cnt;
  logic is_write, next_is_write;
  logic next_ce_n, next_we_n, next_oe_n, next_doe, done, next_done;
  logic [FLASH_ADDR_W-1:0] next_addr;
  logic [FLASH_DATA_W-1:0] next_dout, rdata, next_rdata, din_meta, din_sync;

  assign cyc.done = done;
  assign cyc.rdata = rdata;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_is_write = is_write;
    next_ce_n = chip_sel_n;
    next_we_n = write_en_n;
    next_oe_n = out_en_n;
    next_doe = data_lines_oe;
    next_addr = flash_addr;
    next_dout = data_lines_out;
    next_rdata = rdata;
    next_done = 1'b0;
    case (state)
      C_IDLE: if (cyc.start) begin
        next_state = C_SETUP;
        next_is_write = cyc.write;
        next_addr = cyc.addr;
        next_dout = cyc.wdata;
        next_ce_n = 1'b0;
        next_doe = cyc.write;
        next_cnt = '0;
      end
      C_SETUP: begin
        next_state = C_PULSE;
        // write strobe latches address and data
        if (is_write) next_we_n = 1'b0;
        else next_oe_n = 1'b0;
      end
      C_PULSE: begin
        next_cnt = cnt + 16'h0001;
        if (cnt == (is_write ? WP_CYC : ACC_CYC + SYNC_CYC) - 16'h0001) begin
          next_state = C_RECOV;
          next_cnt = '0;
          next_we_n = 1'b1;
          next_oe_n = 1'b1;
          next_ce_n = 1'b1;
          if (!is_write) next_rdata = din_sync;
        end
      end
      C_RECOV: begin
        next_cnt = cnt + 16'h0001;
        if (cnt == WPH_CYC - 16'h0001) begin
          next_state = C_IDLE;
          next_doe = 1'b0;
          next_done = 1'b1;
        end
      end
      default: next_state = C_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= C_IDLE;
      cnt <= '0;
      is_write <= 1'b0;
      chip_sel_n <= 1'b1;
      write_en_n <= 1'b1;
      out_en_n <= 1'b1;
      data_lines_oe <= 1'b0;
      flash_addr <= '0;
      data_lines_out <= '0;
      rdata <= '0;
      done <= 1'b0;
      din_meta <= '0;
      din_sync <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      is_write <= next_is_write;
      chip_sel_n <= next_ce_n;
      write_en_n <= next_we_n;
      out_en_n <= next_oe_n;
      data_lines_oe <= next_doe;
      flash_addr <= next_addr;
      data_lines_out <= next_dout;
      rdata <= next_rdata;
      done <= next_done;
      din_meta <= data_lines_in;
      din_sync <= din_meta;
    end
  end
endmodule // flash_bus_cycle

// File: verification/flash_host_assertions.sv
// pin-level checks on the flash host controller
`timescale 1ns/100ps
module flash_host_assertions
  import flash_host_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [FLASH_ADDR_W-1:0] flash_addr,
  input wire logic chip_sel_n,
  input wire logic write_en_n,
  input wire logic out_en_n,
  input wire logic [FLASH_DATA_W-1:0] data_lines_out,
  input wire logic data_lines_oe,
  input wire logic flash_reset_n,
  input wire logic irq
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  oe_read_a: assert property (data_lines_oe |-> out_en_n) else $error("drive in read");
  we_oe_a: assert property (write_en_n || out_en_n) else $error("both strobes low");
  we_qual_a: assert property (!write_en_n |-> !chip_sel_n && data_lines_oe)
    else $error("write strobe unqualified");
  we_width_a: assert property ($fell(write_en_n) |-> !write_en_n [*5] ##1 write_en_n)
    else $error("write strobe width");
  cycle_hold_a: assert property (!write_en_n |-> $stable({flash_addr, data_lines_out}))
    else $error("address or data moved");
  data_hold_a: assert property ($rose(write_en_n) |-> data_lines_oe [*3])
    else $error("data hold short");
  read_len_a: assert property ($fell(out_en_n) |-> (!out_en_n && !chip_sel_n) [*8])
    else $error("read strobe short");
  pin_reset_a: assert property ($rose(rst_b) |-> !flash_reset_n [*8])
    else $error("reset pulse short");
  cover property ($fell(write_en_n));
  cover property ($fell(out_en_n));
  cover property ($rose(irq));
endmodule // flash_host_assertions
bind flash_host_ctrl flash_host_assertions u_chk (.clock, .rst_b, .flash_addr, .chip_sel_n,
  .write_en_n, .out_en_n, .data_lines_out, .data_lines_oe, .flash_reset_n, .irq);

// File: verification/flash_model.sv
// behavioural byte-wide flash device facing the host controller
`timescale 1ns/100ps
module flash_model
  import flash_host_pkg::*;
#(parameter int PROT = 31, parameter int PROG_NS = 300, parameter int ERASE_NS = 3000)
(
  input wire logic [FLASH_ADDR_W-1:0] flash_addr,
  input wire logic chip_sel_n,
  input wire logic write_en_n,
  input wire logic out_en_n,
  input wire logic [FLASH_DATA_W-1:0] data_lines_out,
  input wire logic flash_reset_n,
  output logic [FLASH_DATA_W-1:0] data_lines_in,
  output logic ready_busy_out_n
);
  logic [7:0] mem [int];
  logic [7:0] last = 8'h00;
  logic susp = 1'b0, byp = 1'b0, armed = 1'b0, tog = 1'b0, supply_ok = 1'b1;
  int cnt = 0, busy = 0;
  initial data_lines_in = 8'h00;
  // busy while an algorithm runs unsuspended
  always #10 if (busy > 0 && !susp) busy -= 10;
  assign ready_busy_out_n = busy == 0 || susp;
  function automatic logic [7:0] rdb(input int a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction
  // named sector erased, or every sector on chip erase; protected group kept
  task automatic wipe(input int s);
    int ks[$];
    foreach (mem[k])
      if ((s < 0 || k / SECTOR_BYTES == s) && k / SECTOR_BYTES != PROT) ks.push_back(k);
    foreach (ks[i]) mem.delete(ks[i]);
    if (s != PROT) busy = s < 0 ? 100 * ERASE_NS : ERASE_NS;
  endtask
  // command decoder, programming only clears bits
  task automatic cmd(input int a, input logic [7:0] d);
    if (armed) begin
      armed = 1'b0;
      last = d;
      if (a / SECTOR_BYTES != PROT) mem[a] = rdb(a) & d;
      if (a / SECTOR_BYTES != PROT) busy = PROG_NS;
    end else if (byp && cnt == 0 && d == CMD_PROGRAM) armed = 1'b1;
    else if (byp && d == CMD_BYPASS_EXIT1) cnt = 9;
    else if (cnt == 9) begin
      byp = 1'b0;
      cnt = 0;
    end else if (d == CMD_SUSPEND && busy > 0) susp = 1'b1;
    else if (d == CMD_RESUME && susp) susp = 1'b0;
    else if (d == CMD_SECTOR_ERASE && busy > 0) wipe(a / SECTOR_BYTES);
    else if (cnt == 2) begin
      armed = d == CMD_PROGRAM;
      byp = d == CMD_BYPASS;
      cnt = d == CMD_ERASE_SETUP ? 3 : 0;
    end else if (cnt == 5) begin
      cnt = 0;
      wipe(d == CMD_CHIP_ERASE ? -1 : a / SECTOR_BYTES);
    end else cnt = d == ((cnt == 1 || cnt == 4) ? CMD_UNLOCK2 : CMD_UNLOCK1) ? cnt + 1 : 0;
  endtask
  // each write cycle feeds the decoder, none on a low supply
  always @(negedge write_en_n)
    if (!chip_sel_n && flash_reset_n && supply_ok) cmd(int'(flash_addr), data_lines_out);
  // reset pin aborts and returns to array read
  always @(negedge flash_reset_n) begin
    {susp, byp, armed} = 3'b000;
    busy = 0;
    cnt = 0;
  end
  // drive only when selected and enabled; released lines keep changing
  always @(negedge out_en_n or posedge out_en_n or posedge chip_sel_n) begin
    tog = !tog;
    if (!out_en_n && !chip_sel_n)
      data_lines_in = busy > 0 && !susp ? {~last[7], tog, 6'h00} : rdb(int'(flash_addr));
    else data_lines_in = ~data_lines_in;
  end
endmodule // flash_model

// File: verification/tb.sv
// self-checking bench for the flash host controller
`timescale 1ns/100ps
module tb;
  import flash_host_pkg::*;
  localparam logic W = 1'b1, R = 1'b0;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, chip_sel_n, write_en_n, out_en_n, irq;
  logic data_lines_oe, flash_reset_n, ready_busy_out_n;
  logic [1:0] bresp, rresp, resp;
  logic [FLASH_ADDR_W-1:0] flash_addr;
  logic [7:0] data_lines_out, data_lines_in, bus_in;
  int failures = 0, check_count = 0;
  always #5 clock = ~clock;
  assign bus_in = data_lines_oe ? data_lines_out : data_lines_in;
  flash_host_ctrl uut (.clock, .rst_b, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf),
    .wvalid, .wready, .bresp, .bvalid, .bready(1'b1), .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready(1'b1), .flash_addr, .chip_sel_n, .write_en_n, .out_en_n,
    .data_lines_out, .data_lines_oe, .data_lines_in(bus_in), .flash_reset_n,
    .ready_busy_out_n, .irq);
  flash_model dev (.flash_addr, .chip_sel_n, .write_en_n, .out_en_n, .data_lines_out,
    .flash_reset_n, .data_lines_in, .ready_busy_out_n);
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) failures++;
    if (seen !== exp) $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
  endtask
  // one register access; handshakes sampled mid-cycle, released after the edge
  task automatic x(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic aw_t, w_t, ar_t, fin;
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= w;
    wvalid <= w;
    arvalid <= !w;
    do begin
      @(negedge clock);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      ar_t = arvalid && arready;
      fin = w ? bvalid : rvalid;
      resp = w ? bresp : rresp;
      if (!w) v = rdata;
      @(posedge clock);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (ar_t) arvalid <= 1'b0;
    end while (fin !== 1'b1);
  endtask
  task automatic op(input op_t o, input logic [31:0] a, input logic [7:0] d, input logic nw);
    x(W, REG_IRQ_STAT, 32'h3);
    x(W, REG_ADDR, a);
    x(W, REG_WDATA, {24'h0, d});
    x(W, REG_CTRL, {27'h0, nw, o});
    do x(R, REG_STATUS, 32'h0); while (v[ST_BUSY] !== 1'b0);
    x(R, REG_IRQ_STAT, 32'h0);
  endtask
  task automatic pk(input logic [31:0] a, input logic [7:0] e);
    op(OP_READ, a, 8'h00, R);
    x(R, REG_RDATA, 32'h0);
    chk("flash byte", v, {24'h0, e});
  endtask
  task automatic chk_irq(input logic [31:0] m, input logic e);
    x(W, REG_IRQ_MASK, m);
    @(negedge clock);
    chk("irq", irq, e);
    @(posedge clock);
  endtask
  task automatic t_reset();
    x(R, REG_STATUS, 32'h0);
    chk("busy in recovery", v[ST_BUSY], 1'b1);
    x(W, REG_CTRL, 32'h0);
    x(R, 8'h1c, 32'h0);
    chk("unmapped read", resp, 2'b10);
    x(W, 8'h1c, 32'h1);
    chk("unmapped write", resp, 2'b10);
    do x(R, REG_IRQ_STAT, 32'h0); while (v[IRQ_DONE] !== 1'b1);
    chk("reset pin", flash_reset_n, 1'b1);
    chk("busy refusal", v[IRQ_REJECT], 1'b1);
  endtask
  task automatic t_prog();
    op(OP_PROGRAM, 32'h00ffff, 8'h3c, R);
    chk("program", v, 32'h1);
    op(OP_PROGRAM, 32'h012345, 8'h5a, R);
    op(OP_PROGRAM, 32'h012345, 8'ha5, R);
    pk(32'h012345, 8'h00);
    pk(32'h1fffff, 8'hff);
    op(OP_SECTOR_ERASE, 32'h010000, 8'h00, R);
    chk("erase", v, 32'h1);
    pk(32'h012345, 8'hff);
    pk(32'h00ffff, 8'h3c);
    op(OP_PROGRAM, 32'h1f0000, 8'h00, R);
    chk("protected", v, 32'h2);
    pk(32'h1f0000, 8'hff);
  endtask
  task automatic t_bypass();
    op(OP_BYPASS_ENTER, 32'h0, 8'h00, R);
    chk("bypass on", v, 32'h1);
    op(OP_BYPASS_PROG, 32'h020001, 8'h81, R);
    op(OP_BYPASS_PROG, 32'h030002, 8'h18, R);
    op(OP_BYPASS_EXIT, 32'h0, 8'h00, R);
    x(R, REG_STATUS, 32'h0);
    chk("bypass off", v[ST_BYPASS], 1'b0);
    pk(32'h020001, 8'h81);
    pk(32'h030002, 8'h18);
  endtask
  task automatic t_suspend();
    op(OP_SECTOR_ERASE, 32'h020000, 8'h00, W);
    op(OP_SECTOR_ADD, 32'h030000, 8'h00, W);
    op(OP_SUSPEND, 32'h020000, 8'h00, R);
    x(R, REG_STATUS, 32'h0);
    chk("suspended", v[ST_SUSP], 1'b1);
    pk(32'h00ffff, 8'h3c);
    op(OP_RESUME, 32'h020000, 8'h00, R);
    op(OP_WAIT_READY, 32'h0, 8'h00, R);
    chk("resumed", v[IRQ_DONE], 1'b1);
    pk(32'h020001, 8'hff);
    pk(32'h030002, 8'hff);
  endtask
  task automatic t_hw_reset();
    op(OP_CHIP_ERASE, 32'h0, 8'h00, W);
    op(OP_HW_RESET, 32'h0, 8'h00, R);
    chk("ready after abort", ready_busy_out_n, 1'b1);
    pk(32'h00ffff, 8'hff);
  endtask
  task automatic t_irq();
    op(OP_SW_RESET, 32'h0, 8'h00, R);
    chk_irq(32'h1, 1'b1);
    chk_irq(32'h2, 1'b0);
    x(W, REG_CTRL, 32'hd);
    chk_irq(32'h2, 1'b1);
    x(W, REG_IRQ_STAT, 32'h1);
    chk_irq(32'h1, 1'b0);
  endtask
  task automatic print_verdict();
    if (failures == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    t_reset();
    t_prog();
    t_bypass();
    t_suspend();
    t_hw_reset();
    t_irq();
    print_verdict();
  end
  // watchdog, well past the expected run of some 6000 cycles
  initial begin
    repeat (40000) @(posedge clock);
    failures++;
    print_verdict();
  end
endmodule // tb
